// file: shared/jtag_tap_params.svh
// How it works
// - Instruction register is four bits wide
// - All shift paths move LSB first
// - Opcode 0 drives pins from chain latches
// - External test: capture pins, shift, update outputs
// - Each pin: pull disable, control, data, input
// - Opcode 1 selects ID; default after reset
// - ID holds version, part code, maker code
// - ID captured at Capture-DR, shifted out
// - Opcode 2 samples and preloads, pins untouched
// - Opcode C selects reset bit, TAP unaffected
// - Reset bit high resets chip immediately
// - Release keeps reset for selected time-out
// - Chip reset tri-states pads except under EXTEST, no HIGHZ opcode
// - Opcode F selects single bypass stage
// - Bypass captures zero, shifts in Shift-DR
// - Port enabled by fuse and clear disable bit
// - Scan is paced by the chip clock, which samples TCK
// - Five TMS-high TCK periods reach Test-Logic-Reset
`ifndef JTAG_TAP_PARAMS_SVH
`define JTAG_TAP_PARAMS_SVH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define IR_WIDTH 4
`define OP_EXTEST 4'h0
`define OP_IDCODE 4'h1
`define OP_SAMPLE 4'h2
`define OP_CHIP_RESET 4'hC
`define OP_BYPASS 4'hF
`define IR_CAPTURE 4'h1

// ----------------------------------------
// Identification layout
// ----------------------------------------
`define ID_WIDTH 32
`define ID_VER_W 4
`define ID_PART_W 16
`define ID_MFR_W 11
`define ID_MARK 1'h1

// ----------------------------------------
// Boundary cells per pin
// ----------------------------------------
`define CELLS_PER_PIN 4
`define CELL_PUD 0
`define CELL_OC 1
`define CELL_OD 2
`define CELL_ID 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 10
`define RST_TOUT_SHORT_US 4
`define RST_TOUT_LONG_US 65000
`define TMS_RESET_BITS 5

`endif

// file: shared/jtag_tap_pkg.sv
package jtag_tap_pkg;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDCODE, SEL_BSCAN, SEL_RESET
  } dr_sel_e;

  typedef struct packed {
    logic pull_disable;
    logic out_en;
    logic out_data;
  } pin_ctl_s;

endpackage

// file: hw/tap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tap_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// file: hw/jtag_tap.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtag_tap_params.svh"
module jtag_tap import jtag_tap_pkg::*; #(
  parameter int PIN_COUNT = 8,
  parameter logic [`ID_VER_W-1:0] ID_VERSION = 4'h0,
  // Arbitrary neutral identity values
  parameter logic [`ID_PART_W-1:0] ID_PART = 16'h1234,
  parameter logic [`ID_MFR_W-1:0] ID_MFR = 11'h055,
  parameter int TOUT_W = 20,
  parameter int unsigned TOUT_SHORT_CYC = `RST_TOUT_SHORT_US * `CLK_MHZ,
  parameter int unsigned TOUT_LONG_CYC = `RST_TOUT_LONG_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Enable controls
  input wire logic tap_enable_fuse,
  input wire logic tap_disable_bit,
  // Clock option: long reset time-out
  input wire logic timeout_long_sel,
  // Port pins
  input wire logic [PIN_COUNT-1:0] pin_in,
  input wire pin_ctl_s [PIN_COUNT-1:0] core_ctl,
  output pin_ctl_s [PIN_COUNT-1:0] pad_ctl,
  // Chip reset
  output logic chip_reset
);
  localparam int CHAIN = PIN_COUNT * `CELLS_PER_PIN;
  localparam logic [`ID_WIDTH-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, `ID_MARK};

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  // TCK is only sampled, so it must stay well below half the clock rate
  logic tck_s, tms_s, tdi_s, tck_d;
  logic [PIN_COUNT-1:0] pin_s;

  tap_sync #(.WIDTH(3)) u_sync_tap (
    .clk(clk),
    .rst(rst),
    .d({tck, tms, tdi}),
    .q({tck_s, tms_s, tdi_s})
  );

  tap_sync #(.WIDTH(PIN_COUNT)) u_sync_pins (
    .clk(clk),
    .rst(rst),
    .d(pin_in),
    .q(pin_s)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;
  wire tap_on = tap_enable_fuse & ~tap_disable_bit;

  // ----------------------------------------
  // Controller state machine
  // ----------------------------------------
  tap_state_e state, next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: next_state = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_RESET;
    end else if (!tap_on) begin
      state <= ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  logic [`IR_WIDTH-1:0] ir_shift, ir;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_shift <= '0;
      ir <= `OP_IDCODE;
    end else if (state == ST_RESET) begin
      ir <= `OP_IDCODE;
    end else if (tck_rise && state == ST_CAP_IR) begin
      ir_shift <= `IR_CAPTURE;
    end else if (tck_rise && state == ST_SH_IR) begin
      ir_shift <= {tdi_s, ir_shift[`IR_WIDTH-1:1]};
    end else if (tck_fall && state == ST_UPD_IR) begin
      ir <= ir_shift;
    end
  end

  // ----------------------------------------
  // Data path decode
  // ----------------------------------------
  wire is_extest = (ir == `OP_EXTEST);
  wire is_sample = (ir == `OP_SAMPLE);
  wire is_idcode = (ir == `OP_IDCODE);
  wire is_reset = (ir == `OP_CHIP_RESET);
  // Anything unassigned falls through to the one-bit path
  wire dr_sel_e dr_sel = (is_extest | is_sample) ? SEL_BSCAN :
                         is_idcode ? SEL_IDCODE :
                         is_reset ? SEL_RESET :
                         SEL_BYPASS;

  wire dr_capture = tck_rise && (state == ST_CAP_DR);
  wire dr_shift = tck_rise && (state == ST_SH_DR);
  wire dr_update = tck_fall && (state == ST_UPD_DR);

  // ----------------------------------------
  // Bypass, identification and reset bit
  // ----------------------------------------
  logic bypass;
  logic [`ID_WIDTH-1:0] id_shift;
  logic reset_bit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bypass <= 1'b0;
    end else if (dr_capture && dr_sel == SEL_BYPASS) begin
      bypass <= 1'b0;
    end else if (dr_shift && dr_sel == SEL_BYPASS) begin
      bypass <= tdi_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_shift <= '0;
    end else if (dr_capture && dr_sel == SEL_IDCODE) begin
      id_shift <= ID_VALUE;
    end else if (dr_shift && dr_sel == SEL_IDCODE) begin
      id_shift <= {tdi_s, id_shift[`ID_WIDTH-1:1]};
    end
  end

  // Not reset by the TAP state machine, only by the block reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_bit <= 1'b0;
    end else if (dr_shift && dr_sel == SEL_RESET) begin
      reset_bit <= tdi_s;
    end
  end

  // ----------------------------------------
  // Boundary chain
  // ----------------------------------------
  logic [CHAIN-1:0] bs_shift, bs_latch, bs_capture;
  pin_ctl_s [PIN_COUNT-1:0] latch_ctl;

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    assign bs_capture[i*`CELLS_PER_PIN+`CELL_PUD] = core_ctl[i].pull_disable;
    assign bs_capture[i*`CELLS_PER_PIN+`CELL_OC] = core_ctl[i].out_en;
    assign bs_capture[i*`CELLS_PER_PIN+`CELL_OD] = core_ctl[i].out_data;
    assign bs_capture[i*`CELLS_PER_PIN+`CELL_ID] = pin_s[i];
    assign latch_ctl[i].pull_disable = bs_latch[i*`CELLS_PER_PIN+`CELL_PUD];
    assign latch_ctl[i].out_en = bs_latch[i*`CELLS_PER_PIN+`CELL_OC];
    assign latch_ctl[i].out_data = bs_latch[i*`CELLS_PER_PIN+`CELL_OD];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bs_shift <= '0;
    end else if (dr_capture && dr_sel == SEL_BSCAN) begin
      bs_shift <= bs_capture;
    end else if (dr_shift && dr_sel == SEL_BSCAN) begin
      bs_shift <= {tdi_s, bs_shift[CHAIN-1:1]};
    end
  end

  // Latches reset to all-off; a preload is still advised before external test
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bs_latch <= '0;
    end else if (dr_update && dr_sel == SEL_BSCAN) begin
      bs_latch <= bs_shift;
    end
  end

  // ----------------------------------------
  // Chip reset and time-out
  // ----------------------------------------
  logic [TOUT_W-1:0] tout_cnt;
  wire [TOUT_W-1:0] tout_load = timeout_long_sel ? TOUT_W'(TOUT_LONG_CYC) : TOUT_W'(TOUT_SHORT_CYC);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tout_cnt <= '0;
    end else if (reset_bit) begin
      tout_cnt <= tout_load;
    end else if (tout_cnt != '0) begin
      tout_cnt <= tout_cnt - 1'b1;
    end
  end

  // Unlatched on purpose: reset follows the bit while it is shifted
  assign chip_reset = reset_bit | (tout_cnt != '0);

  // ----------------------------------------
  // Pad control
  // ----------------------------------------
  wire pin_ctl_s reset_ctl = '{pull_disable: 1'b1, out_en: 1'b0, out_data: 1'b0};

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pad
    assign pad_ctl[i] = is_extest ? latch_ctl[i] :
                        chip_reset ? reset_ctl :
                        core_ctl[i];
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  wire dr_lsb = (dr_sel == SEL_IDCODE) ? id_shift[0] :
                (dr_sel == SEL_BSCAN) ? bs_shift[0] :
                (dr_sel == SEL_RESET) ? reset_bit : bypass;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!tap_on) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= (state == ST_SH_IR) ? ir_shift[0] : dr_lsb;
      tdo_oe <= (state == ST_SH_IR) || (state == ST_SH_DR);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [2:0] tms_run;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tms_run <= 3'h0;
    end else if (tck_rise) begin
      tms_run <= !tms_s ? 3'h0 : (tms_run == 3'h7) ? 3'h7 : tms_run + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tms_reset: assert property (tms_run >= 3'(`TMS_RESET_BITS) |-> state == ST_RESET)
    else $error("five TMS-high periods did not reach reset");
  a_default_ir: assert property (state == ST_RESET |=> ir == `OP_IDCODE)
    else $error("identification not default after reset");
  a_bypass_zero: assert property (dr_capture && dr_sel == SEL_BYPASS |=> !bypass)
    else $error("bypass did not capture zero");
  a_bypass_shift: assert property (dr_shift && dr_sel == SEL_BYPASS |=> bypass == $past(tdi_s))
    else $error("bypass did not shift tdi");
  a_id_capture: assert property (dr_capture && dr_sel == SEL_IDCODE |=> id_shift == ID_VALUE)
    else $error("identification value not captured");
  a_lsb_first: assert property (tck_fall && state == ST_SH_DR && dr_sel == SEL_IDCODE
    |=> tdo == $past(id_shift[0]) && tdo_oe)
    else $error("tdo not lsb of id path");
  a_reset_now: assert property (dr_shift && dr_sel == SEL_RESET && tdi_s |=> chip_reset)
    else $error("reset bit did not reset chip at once");
  a_reset_hold: assert property ($fell(reset_bit) |-> chip_reset [*8])
    else $error("chip reset dropped before time-out");
  a_reset_tristate: assert property (chip_reset && !is_extest |-> pad_ctl[0].out_en == 1'b0)
    else $error("pad driven during chip reset");
  a_update_latch: assert property (dr_update && dr_sel == SEL_BSCAN |=> bs_latch == $past(bs_shift))
    else $error("chain not moved to latches at update");
  a_disabled_idle: assert property (!tap_on |=> state == ST_RESET && !tdo_oe)
    else $error("port active while disabled");

  c_id_shift: cover property (dr_shift && dr_sel == SEL_IDCODE);
  c_extest: cover property (is_extest && dr_update);
  c_sample: cover property (is_sample && dr_capture);
  c_reset_release: cover property ($fell(reset_bit));
endmodule
`default_nettype wire

// file: test/jtag_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_ctrl_model (
  // System clock for pacing
  input wire logic clk,
  // Test access pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  // Collected shift-out data
  output logic rx_valid,
  output logic [31:0] rx_data
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    rx_valid = 1'b0;
    rx_data = 32'h0;
  end

  // ----------------------------------------
  // One TCK period, 8 clk, TDO taken at the rise
  // ----------------------------------------
  // Callers start on a clk edge, so the period stays at 8 clk
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    o = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask

  // Idle data line toggles so a stale level never looks valid
  task automatic nav(input logic m);
    logic o;
    step(m, ~tdi, o);
  endtask

  task automatic tap_reset();
    repeat (5) nav(1'b1);
    nav(1'b0);
  endtask

  // ----------------------------------------
  // Full IR or DR scan from Idle back to Idle
  // ----------------------------------------
  task automatic scan(input logic ir, input int n, input logic [31:0] din);
    logic [31:0] dout;
    logic o;
    dout = 32'h0;
    nav(1'b0);
    nav(1'b1);
    if (ir) begin
      nav(1'b1);
    end
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    nav(1'b1);
    nav(1'b0);
    @(posedge clk);
    rx_data <= dout;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import jtag_tap_pkg::*;;
  localparam int SHORT = 40;
  localparam int LONG = 80;
  // Arbitrary identity values
  localparam logic [15:0] ID_P = 16'h1234;
  localparam logic [10:0] ID_M = 11'h055;
  localparam logic [31:0] ID_VAL = {4'h0, ID_P, ID_M, 1'b1};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, fuse, dis, lsel, chip_reset, rx_valid;
  logic [31:0] rx_data, seed, d, w;
  logic [7:0] pin_in;
  pin_ctl_s [7:0] core_ctl;
  pin_ctl_s [7:0] pad_ctl;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [3:0] ops[$] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int tout;

  always #50 clk = ~clk;

  jtag_tap #(.PIN_COUNT(8), .ID_PART(ID_P), .ID_MFR(ID_M), .TOUT_SHORT_CYC(SHORT), .TOUT_LONG_CYC(LONG)) u_dut (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .tap_enable_fuse(fuse), .tap_disable_bit(dis), .timeout_long_sel(lsel),
    .pin_in(pin_in), .core_ctl(core_ctl), .pad_ctl(pad_ctl), .chip_reset(chip_reset));

  // Pulled-up line: a released TDO reads high
  wire tdo_line = tdo_oe ? tdo : 1'b1;

  jtag_ctrl_model u_ctrl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line),
    .rx_valid(rx_valid), .rx_data(rx_data));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] capbits(input logic [7:0] p, input logic [23:0] c);
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < 8; i++) e[4*i +: 4] = {p[i], c[3*i], c[3*i+1], c[3*i+2]};
    return e;
  endfunction

  function automatic logic [31:0] pads(input logic [31:0] v);
    logic [31:0] p;
    p = 32'h0;
    for (int i = 0; i < 8; i++) p[3*i +: 3] = {v[4*i], v[4*i+1], v[4*i+2]};
    return p;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
  endtask

  task automatic ir(input logic [3:0] op);
    note(32'h1, 32'hF);
    u_ctrl.scan(1'b1, 4, {28'h0, op});
  endtask

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Scan results against the oldest note
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(rx_data, ~rx_data);
      end else begin
        check(rx_data & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  // Bounded at 20000 cycles, about four times the planned scan run of about 5000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h7DBA;
    fuse <= 1'b1;
    dis <= 1'b0;
    lsel <= 1'b0;
    pin_in <= 8'h00;
    core_ctl <= 24'h000000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    u_ctrl.tap_reset();
    note(ID_VAL, 32'hFFFFFFFF);
    u_ctrl.scan(1'b0, 32, rnd());
    check({31'h0, tdo_oe}, 32'h0);
    foreach (ops[k]) begin
      ir(ops[k]);
      d = rnd();
      note({d[6:0], 1'b0}, 32'hFF);
      u_ctrl.scan(1'b0, 8, d);
    end
    @(posedge clk);
    d = rnd();
    pin_in <= d[7:0];
    core_ctl <= d[31:8];
    ir(4'h2);
    w = rnd();
    note(capbits(d[7:0], core_ctl), 32'hFFFFFFFF);
    u_ctrl.scan(1'b0, 32, w);
    check(32'(pad_ctl), 32'(core_ctl));
    ir(4'h0);
    check(32'(pad_ctl), pads(w));
    d = rnd();
    pin_in <= d[7:0];
    w = rnd();
    note(capbits(d[7:0], core_ctl), 32'hFFFFFFFF);
    u_ctrl.scan(1'b0, 32, w);
    check(32'(pad_ctl), pads(w));
    for (int s = 0; s < 2; s++) begin
      lsel <= s[0];
      tout = s ? LONG : SHORT;
      ir(4'hC);
      note(32'h0, 32'h1);
      u_ctrl.scan(1'b0, 1, 32'h1);
      check({31'h0, chip_reset}, 32'h1);
      check(32'(pad_ctl) & 32'h492492, 32'h0);
      note(32'h1, 32'h1);
      u_ctrl.scan(1'b0, 1, 32'h0);
      repeat (tout - 25) @(posedge clk);
      check({31'h0, chip_reset}, 32'h1);
      repeat (30) @(posedge clk);
      check({31'h0, chip_reset}, 32'h0);
    end
    for (int c = 0; c < 2; c++) begin
      if (c == 0) dis <= 1'b1;
      else fuse <= 1'b0;
      note(32'hF, 32'hF);
      u_ctrl.scan(1'b1, 4, 32'hF);
      fuse <= 1'b1;
      dis <= 1'b0;
      note(ID_VAL, 32'hFFFFFFFF);
      u_ctrl.scan(1'b0, 32, rnd());
    end
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
